// *** ptr_router.sv ***
// peripheral trigger router: steers timer, interval timer, calendar,
// comparator and external pin triggers to their consumers.
// assumes all sources are synchronous to SYS_CLK; registered routes,
// so every output lands one cycle after its source.
`timescale 1ns/1ps

// Function
// - alt enable clear routes timer one ch0 flag to A and ch1 flag to B.
// - a 4-bit select picks the converter trigger, one bit steers A or B.
// - each timer has a 4-bit trigger select over the same source set.
// - the low-power timer trigger is routed to the comparator trigger input.
// - timer one timebase reaches every timer, used where enabled.
// - the low-power timer trigger reaches the touch unit when chosen.
// - when requested, timer one ch0 modulates the serial transmit output.
// - interval flags 0 and 1 request dma channels 0 and 1 when enabled.
module ptr_router
    import ptr_pkg::*;
#(
    parameter int NUM_TIMERS = 2
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire ptr_wb_req_t WB_REQ,
    output ptr_wb_rsp_t WB_RSP,
    input wire ptr_srcs_t SRCS,
    input wire logic TIMER1_TIMEBASE,
    input wire logic TIMER1_CH0_OUT,
    input wire logic SERIAL_TX_IN,
    output logic CONV_TRIG_A,
    output logic CONV_TRIG_B,
    output logic [NUM_TIMERS-1:0] TIMER_TRIG,
    output logic [NUM_TIMERS-1:0] TIMER_GLOBAL_TB,
    output logic CMP_TRIG,
    output logic TOUCH_TRIG,
    output logic SERIAL_TX_PIN,
    output logic SERIAL_RX_CMP_SEL,
    output logic TIMER1_CH0_CMP_SEL,
    output logic LOWPOWER_TIMER_CMP_SEL,
    output logic DMA_REQ0,
    output logic DMA_REQ1
);

    logic [31:0] conv_cfg_q;
    logic [31:0] tmr_cfg_q;
    logic [31:0] ser_cfg_q;
    logic [31:0] misc_cfg_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic wr_en;
    logic access;

    // decode of the shared 4-bit source encoding
    function automatic logic pick_src(input logic [3:0] sel,
                                      input ptr_srcs_t s);
        logic r;
        r = 1'b0;
        case (sel)
            PTR_SRC_EXT: r = s.ext_pin;
            PTR_SRC_CMP: r = s.cmp_out;
            PTR_SRC_IFLAG0: r = s.iflag0;
            PTR_SRC_IFLAG1: r = s.iflag1;
            PTR_SRC_TOF0: r = s.overflow[0];
            PTR_SRC_TOF1: r = s.overflow[1];
            PTR_SRC_ALARM: r = s.alarm;
            PTR_SRC_SECONDS: r = s.seconds;
            PTR_SRC_LOWPOWER_TIMER: r = s.lowpower_timer_trig;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // byte-lane merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign access = WB_REQ.cyc && WB_REQ.stb && !ack_q;
    assign wr_en = access && WB_REQ.we;

    // one-wait-state ack; drops the cycle after it is given
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    // config writes, bus clock only; reset restores defaults
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            conv_cfg_q <= PTR_CONV_CFG_RST;
            tmr_cfg_q <= PTR_TMR_CFG_RST;
            ser_cfg_q <= PTR_SER_CFG_RST;
            misc_cfg_q <= PTR_MISC_CFG_RST;
        end else if (wr_en) begin
            case (WB_REQ.adr)
                PTR_CONV_CFG_OFS:
                    conv_cfg_q <= merge(conv_cfg_q, WB_REQ.dat, WB_REQ.sel);
                PTR_TMR_CFG_OFS:
                    tmr_cfg_q <= merge(tmr_cfg_q, WB_REQ.dat, WB_REQ.sel);
                PTR_SER_CFG_OFS:
                    ser_cfg_q <= merge(ser_cfg_q, WB_REQ.dat, WB_REQ.sel);
                PTR_MISC_CFG_OFS:
                    misc_cfg_q <= merge(misc_cfg_q, WB_REQ.dat, WB_REQ.sel);
                default: ;
            endcase
        end
    end

    // read data; status shows live routed outputs
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdat_q <= PTR_UNMAPPED_DATA;
        end else if (access && !WB_REQ.we) begin
            case (WB_REQ.adr)
                PTR_CONV_CFG_OFS: rdat_q <= conv_cfg_q;
                PTR_TMR_CFG_OFS: rdat_q <= tmr_cfg_q;
                PTR_SER_CFG_OFS: rdat_q <= ser_cfg_q;
                PTR_MISC_CFG_OFS: rdat_q <= misc_cfg_q;
                PTR_STATUS_OFS: rdat_q <= {22'h0, DMA_REQ1, DMA_REQ0,
                    SERIAL_TX_PIN, TOUCH_TRIG, CMP_TRIG, TIMER_TRIG[0],
                    TIMER_TRIG[1], TIMER_GLOBAL_TB[0], CONV_TRIG_B,
                    CONV_TRIG_A};
                default: rdat_q <= PTR_UNMAPPED_DATA;
            endcase
        end
    end

    assign WB_RSP = {ack_q, rdat_q};

    // converter triggers
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CONV_TRIG_A <= 1'b0;
            CONV_TRIG_B <= 1'b0;
        end else if (!conv_cfg_q[PTR_CONV_ALT_BIT]) begin
            // paired A/B; spacing in stop modes is software's job
            CONV_TRIG_A <= SRCS.ch0_flag;
            CONV_TRIG_B <= SRCS.ch1_flag;
        end else begin
            // one selected source, steered to a single input
            CONV_TRIG_A <= !conv_cfg_q[PTR_CONV_AB_BIT] &&
                pick_src(conv_cfg_q[PTR_CONV_SRC_LSB +: 4], SRCS);
            CONV_TRIG_B <= conv_cfg_q[PTR_CONV_AB_BIT] &&
                pick_src(conv_cfg_q[PTR_CONV_SRC_LSB +: 4], SRCS);
        end
    end

    // per-timer trigger and global timebase
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
        localparam int BASE = t * PTR_TMR_FIELD_W;
        always_ff @(posedge SYS_CLK) begin
            if (RST) begin
                TIMER_TRIG[t] <= 1'b0;
                TIMER_GLOBAL_TB[t] <= 1'b0;
            end else begin
                TIMER_TRIG[t] <= pick_src(
                    tmr_cfg_q[BASE + PTR_TMR_SRC_LSB +: 4], SRCS);
                TIMER_GLOBAL_TB[t] <= TIMER1_TIMEBASE &&
                    tmr_cfg_q[BASE + PTR_TMR_GTB_BIT];
            end
        end
    end

    // comparator and touch triggers follow the low-power timer
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CMP_TRIG <= 1'b0;
            TOUCH_TRIG <= 1'b0;
        end else begin
            CMP_TRIG <= SRCS.lowpower_timer_trig &&
                misc_cfg_q[PTR_MISC_CMP_TRG_BIT];
            TOUCH_TRIG <= SRCS.lowpower_timer_trig &&
                misc_cfg_q[PTR_MISC_TSI_HW_BIT];
        end
    end

    // idle-high line: modulation gates marks with the carrier
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            SERIAL_TX_PIN <= 1'b1;
        end else begin
            SERIAL_TX_PIN <= ser_cfg_q[PTR_SER_TX_BIT] ?
                (SERIAL_TX_IN & TIMER1_CH0_OUT) : SERIAL_TX_IN;
        end
    end

    // static comparator steering levels, no data through here
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            SERIAL_RX_CMP_SEL <= 1'b0;
            TIMER1_CH0_CMP_SEL <= 1'b0;
            LOWPOWER_TIMER_CMP_SEL <= 1'b0;
        end else begin
            SERIAL_RX_CMP_SEL <= ser_cfg_q[PTR_SER_RX_BIT];
            TIMER1_CH0_CMP_SEL <= ser_cfg_q[PTR_SER_CAP_BIT];
            LOWPOWER_TIMER_CMP_SEL <= misc_cfg_q[PTR_MISC_LPT_PIN_BIT];
        end
    end

    // dma requests from the interval flags
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DMA_REQ0 <= 1'b0;
            DMA_REQ1 <= 1'b0;
        end else begin
            DMA_REQ0 <= SRCS.iflag0 &&
                misc_cfg_q[PTR_MISC_DMA0_BIT];
            DMA_REQ1 <= SRCS.iflag1 &&
                misc_cfg_q[PTR_MISC_DMA1_BIT];
        end
    end

endmodule

// *** ptr_pkg.sv ***
// package for the peripheral trigger router: register map, field
// layout, reset values, source encodings and bus signal groups.
// assumes a 32-bit classic wishbone slave port, byte addressed.
package ptr_pkg;

    // register byte offsets
    localparam logic [7:0] PTR_CONV_CFG_OFS = 8'h00;
    localparam logic [7:0] PTR_TMR_CFG_OFS = 8'h04;
    localparam logic [7:0] PTR_SER_CFG_OFS = 8'h08;
    localparam logic [7:0] PTR_MISC_CFG_OFS = 8'h0c;
    localparam logic [7:0] PTR_STATUS_OFS = 8'h10;

    // conv cfg fields
    localparam int PTR_CONV_SRC_LSB = 0;
    localparam int PTR_CONV_AB_BIT = 4;
    localparam int PTR_CONV_ALT_BIT = 7;
    // timer cfg: per timer byte, select in [3:0], timebase enable at 4
    localparam int PTR_TMR_SRC_LSB = 0;
    localparam int PTR_TMR_GTB_BIT = 4;
    localparam int PTR_TMR_FIELD_W = 8;
    // serial cfg fields
    localparam int PTR_SER_TX_BIT = 0;
    localparam int PTR_SER_RX_BIT = 4;
    localparam int PTR_SER_CAP_BIT = 8;
    // misc cfg fields
    localparam int PTR_MISC_CMP_TRG_BIT = 0;
    localparam int PTR_MISC_TSI_HW_BIT = 1;
    localparam int PTR_MISC_DMA0_BIT = 2;
    localparam int PTR_MISC_DMA1_BIT = 3;
    localparam int PTR_MISC_LPT_PIN_BIT = 4;

    // reset values
    localparam logic [31:0] PTR_CONV_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PTR_TMR_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PTR_SER_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PTR_MISC_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PTR_UNMAPPED_DATA = 32'h0000_0000;

    // 4-bit trigger source encodings
    typedef enum logic [3:0] {
        PTR_SRC_EXT = 4'h0,
        PTR_SRC_CMP = 4'h1,
        PTR_SRC_IFLAG0 = 4'h2,
        PTR_SRC_IFLAG1 = 4'h3,
        PTR_SRC_TOF0 = 4'h4,
        PTR_SRC_TOF1 = 4'h5,
        PTR_SRC_ALARM = 4'h6,
        PTR_SRC_SECONDS = 4'h7,
        PTR_SRC_LOWPOWER_TIMER = 4'h8
    } ptr_src_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } ptr_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ptr_wb_rsp_t;

    // trigger sources gathered from the peripherals
    typedef struct packed {
        logic ch0_flag;
        logic ch1_flag;
        logic [1:0] overflow;
        logic iflag0;
        logic iflag1;
        logic alarm;
        logic seconds;
        logic ext_pin;
        logic cmp_out;
        logic lowpower_timer_trig;
    } ptr_srcs_t;

endpackage

// *** ptr_chk.sv ***
// checker: bus handshake and route causes at the router ports.
// assumes binding into ptr_router; one clock, sync reset.
`timescale 1ns/1ps
module ptr_chk
    import ptr_pkg::*;
#(
    parameter int NUM_TIMERS = 2
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire ptr_wb_req_t WB_REQ,
    input wire ptr_wb_rsp_t WB_RSP,
    input wire ptr_srcs_t SRCS,
    input wire logic TIMER1_TIMEBASE,
    input wire logic TIMER1_CH0_OUT,
    input wire logic SERIAL_TX_IN,
    input wire logic CONV_TRIG_A,
    input wire logic [NUM_TIMERS-1:0] TIMER_GLOBAL_TB,
    input wire logic CMP_TRIG,
    input wire logic TOUCH_TRIG,
    input wire logic SERIAL_TX_PIN,
    input wire logic DMA_REQ0,
    input wire logic DMA_REQ1
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire take = WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
    a_ack_take: assert property (take |=> WB_RSP.ack)
        else $error("no ack after request");
    a_ack_pulse: assert property (WB_RSP.ack |=> !WB_RSP.ack)
        else $error("ack too long");
    a_ack_cause: assert property ($rose(WB_RSP.ack) |->
        $past(take))
        else $error("ack without request");
    a_conv_cause: assert property (CONV_TRIG_A |->
        $past(SRCS) != '0)
        else $error("trigger a without source");
    a_dma_zero: assert property (DMA_REQ0 |-> $past(SRCS.iflag0))
        else $error("dma0 without flag");
    a_dma_one: assert property (DMA_REQ1 |-> $past(SRCS.iflag1))
        else $error("dma1 without flag");
    a_cmp_route: assert property (CMP_TRIG |->
        $past(SRCS.lowpower_timer_trig))
        else $error("comparator trigger without cause");
    a_touch_route: assert property (TOUCH_TRIG |->
        $past(SRCS.lowpower_timer_trig))
        else $error("touch trigger without cause");
    a_gtb_route: assert property (|TIMER_GLOBAL_TB |->
        $past(TIMER1_TIMEBASE))
        else $error("timebase without source");
    a_tx_mod: assert property (!SERIAL_TX_PIN |->
        !($past(SERIAL_TX_IN) && $past(TIMER1_CH0_OUT)))
        else $error("tx pin low without cause");
    c_ack: cover property (WB_RSP.ack);
    c_dma: cover property (DMA_REQ0 && DMA_REQ1);
    c_tx_fall: cover property ($fell(SERIAL_TX_PIN));
endmodule
bind ptr_router ptr_chk #(.NUM_TIMERS(NUM_TIMERS)) chk_u (
    .SYS_CLK, .RST, .WB_REQ, .WB_RSP, .SRCS, .TIMER1_TIMEBASE,
    .TIMER1_CH0_OUT, .SERIAL_TX_IN, .CONV_TRIG_A, .TIMER_GLOBAL_TB,
    .CMP_TRIG, .TOUCH_TRIG, .SERIAL_TX_PIN, .DMA_REQ0, .DMA_REQ1);

// *** ptr_peer.sv ***
// partner model: peripherals producing flags and levels.
// assumes the bench commands each pattern; launches on the clock edge.
`timescale 1ns/1ps
module ptr_peer
    import ptr_pkg::*;
(
    input wire logic clk,
    input wire logic [10:0] pat,
    input wire logic [2:0] aux,
    output ptr_srcs_t srcs,
    output logic timebase,
    output logic ch0_out,
    output logic tx_in
);
    // flags leave real timers from flops, so model them registered
    always @(posedge clk) begin
        srcs <= pat;
        {timebase, ch0_out, tx_in} <= aux;
    end
endmodule

// *** tb_top.sv ***
// bench: route rows, source code sweep, bus corners, mid-run reset.
// assumes the router, its bound checker and the peripheral model.
`timescale 1ns/1ps
module tb_top
    import ptr_pkg::*;
;
    typedef struct packed {
        logic [7:0] conv;
        logic [15:0] tmr;
        logic [8:0] ser;
        logic [4:0] misc;
        logic [10:0] src;
        logic [2:0] aux;
        logic [13:0] exp;
    } ptr_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ptr_wb_req_t req = '0;
    ptr_wb_rsp_t rsp;
    logic [10:0] pat = 11'h000;
    logic [2:0] aux = 3'h3;
    ptr_srcs_t srcs;
    logic tb, c0, tx, a, b, cmp, tch, txp, rxs, cs, lps, d0, d1;
    logic [1:0] trg, gtb;
    logic [31:0] rd;
    int n_errors = 0;
    int n_tests = 0;
    ptr_row_t rows [6];
    int map [10] = '{2, 1, 6, 5, 7, 8, 4, 3, 0, 0};
    wire [13:0] obs = {a, b, trg, gtb, cmp, tch, txp, d0, d1, rxs, cs, lps};
    always #5 clk = ~clk;
    ptr_peer peer_u (.clk(clk), .pat(pat), .aux(aux), .srcs(srcs),
        .timebase(tb), .ch0_out(c0), .tx_in(tx));
    ptr_router #(.NUM_TIMERS(2)) dut_u (.SYS_CLK(clk), .RST(rst),
        .WB_REQ(req), .WB_RSP(rsp), .SRCS(srcs), .TIMER1_TIMEBASE(tb),
        .TIMER1_CH0_OUT(c0), .SERIAL_TX_IN(tx), .CONV_TRIG_A(a),
        .CONV_TRIG_B(b), .TIMER_TRIG(trg), .TIMER_GLOBAL_TB(gtb),
        .CMP_TRIG(cmp), .TOUCH_TRIG(tch), .SERIAL_TX_PIN(txp),
        .SERIAL_RX_CMP_SEL(rxs), .TIMER1_CH0_CMP_SEL(cs),
        .LOWPOWER_TIMER_CMP_SEL(lps), .DMA_REQ0(d0), .DMA_REQ1(d1));
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (!ok) begin
            n_errors++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        req <= {1'b1, 1'b1, w, 4'hf, ad, d};
        do begin
            @(posedge clk);
            k++;
        end while (rsp.ack !== 1'b1 && k < 20);
        rd = rsp.dat;
        req <= '0;
        chk(k < 20, "no ack");
    endtask
    task automatic go(input ptr_row_t r);
        wb(1'b1, PTR_CONV_CFG_OFS, {24'h0, r.conv});
        wb(1'b1, PTR_TMR_CFG_OFS, {16'h0, r.tmr});
        wb(1'b1, PTR_SER_CFG_OFS, {23'h0, r.ser});
        wb(1'b1, PTR_MISC_CFG_OFS, {27'h0, r.misc});
        pat <= r.src;
        aux <= r.aux;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(obs === r.exp, "route");
    endtask
    task automatic finish_test();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial begin
        ptr_row_t r;
        rows[0] = {8'h00, 16'h0000, 9'h000, 5'h00, 11'h401, 3'h3, 14'h2020};
        rows[1] = {8'h00, 16'h0000, 9'h000, 5'h00, 11'h200, 3'h3, 14'h1020};
        rows[2] = {8'h88, 16'h0808, 9'h000, 5'h03, 11'h001, 3'h3, 14'h2ce0};
        rows[3] = {8'h95, 16'h0504, 9'h000, 5'h00, 11'h100, 3'h3, 14'h1820};
        rows[4] = {8'h00, 16'h1010, 9'h111, 5'h1c, 11'h060, 3'h5, 14'h031f};
        rows[5] = {8'h00, 16'h1010, 9'h111, 5'h1c, 11'h060, 3'h7, 14'h033f};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, PTR_CONV_CFG_OFS, 32'h0);
        chk(rd === PTR_CONV_CFG_RST, "conv reset");
        wb(1'b0, PTR_MISC_CFG_OFS, 32'h0);
        chk(rd === PTR_MISC_CFG_RST, "misc reset");
        foreach (rows[i]) go(rows[i]);
        // code 9 is outside the source set and must route nothing
        for (int c = 0; c < 10; c++) begin
            r = '0;
            r.conv = {4'h8, c[3:0]};
            r.tmr = {4'h0, c[3:0], 4'h0, c[3:0]};
            r.src = (c < 9) ? 11'h001 << map[c] : 11'h7ff;
            r.aux = 3'h3;
            r.exp = (c < 9) ? 14'h2c20 : 14'h0020;
            go(r);
        end
        wb(1'b1, PTR_STATUS_OFS, 32'hffff_ffff);
        wb(1'b0, PTR_STATUS_OFS, 32'h0);
        chk(rd === 32'h0000_0080, "status");
        wb(1'b1, 8'h14, 32'hffff_ffff);
        wb(1'b0, 8'h14, 32'h0);
        chk(rd === PTR_UNMAPPED_DATA, "unmapped");
        // move a and txp off their reset levels so the reset shows
        wb(1'b1, PTR_SER_CFG_OFS, 32'h0000_0001);
        wb(1'b1, PTR_CONV_CFG_OFS, 32'h0000_0000);
        pat <= 11'h400;
        aux <= 3'h5;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(obs === 14'h2000, "before reset");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(obs === 14'h0020, "reset outputs");
        @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, PTR_TMR_CFG_OFS, 32'h0);
        chk(rd === PTR_TMR_CFG_RST, "timer reset");
        finish_test();
    end
endmodule
